// *** hdl/msr_pkg.sv ***
// Purpose: Shared constants and types for the memory system register bank
// Assumes: 32-bit AXI4-Lite register access, 50 MHz core clock
// Notes: Offsets are byte addresses
`default_nettype none
package msr_pkg;
    localparam logic [7:0] OFF_IF = 8'h2c;
    localparam logic [7:0] OFF_IFS = 8'h30;
    localparam logic [7:0] OFF_IFC = 8'h34;
    localparam logic [7:0] OFF_IEN = 8'h38;
    localparam logic [7:0] OFF_LOCK = 8'h3c;
    localparam logic [7:0] OFF_CMD = 8'h40;
    localparam logic [7:0] OFF_HITS = 8'h44;
    localparam logic [7:0] OFF_MISSES = 8'h48;
    localparam logic [7:0] OFF_TIMEBASE = 8'h50;
    localparam logic [7:0] OFF_MASSLOCK = 8'h54;
    localparam logic [7:0] OFF_LATENCY = 8'h58;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_READCTRL = 8'h04;
    localparam logic [7:0] OFF_WRITECTRL = 8'h08;
    localparam logic [7:0] OFF_BULK_CMD = 8'h0c;
    // Flag bit positions
    localparam int BIT_ERASE = 0;
    localparam int BIT_WRITE = 1;
    localparam int BIT_HOF = 2;
    localparam int BIT_MOF = 3;
    // Command and timebase bit positions
    localparam int BIT_FLUSH = 0;
    localparam int BIT_BEGIN = 1;
    localparam int BIT_HALT = 2;
    localparam int BIT_BULK0 = 8;
    localparam int BIT_BULK1 = 9;
    localparam int BIT_PERIOD = 16;
    localparam logic [15:0] CFG_UNLOCK_CODE = 16'h1b71;
    localparam logic [15:0] BULK_UNLOCK_CODE = 16'h631a;
    localparam logic [15:0] CFG_LOCK_RESET = 16'h0000;
    localparam logic [15:0] BULK_LOCK_RESET = 16'h0001;
    localparam logic [5:0] BASE_RESET = 6'h10;
    localparam logic [7:0] LATENCY_RESET = 8'h00;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] READCTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] WRITECTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
    localparam logic [31:0] READCTRL_MASK = 32'h0000_009f;
    localparam logic [31:0] WRITECTRL_MASK = 32'h0000_0003;
    localparam int CNT_W = 20;
    localparam int LAT_EXTRA = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } msr_wreq_s;

    typedef struct packed {
        logic hit;
        logic miss;
        logic write_done;
        logic erase_done;
    } msr_event_s;
endpackage
`default_nettype wire

// *** hdl/msr_regs.sv ***
// Purpose: Memory system register bank with flags, locks and perf counters
// Assumes: Single clock; flash and cache events arrive as one-cycle pulses
// Notes: Writes to unmapped or reserved addresses answer SLVERR
// Operation
// R1: Miss counter overflow sets flag bit 3
// R2: Hit counter overflow sets flag bit 2
// R3: Write and erase completion set bits 1,0
// R4: Flag-set write ones set flags
// R5: Flag-clear write ones clear flags
// R6: Four enable bits, reset cleared
// R7: Interrupt while any enabled flag set
// R8: Config key 0x1b71 unlocks protected registers
// R9: Config lock bit 0 reads locked state
// R10: Bulk lock refuses both bulk erase commands
// R11: Key 0x631a releases bulk lock, reset locked
// R12: Begin command restarts counters from zero
// R13: Halt command stops counters, values held
// R14: Flush command pulses cache invalidate strobe
// R15: Twenty-bit hit counter since begin
// R16: Twenty-bit miss counter since begin
// R17: Running bit clears at counter maximum
// R18: Period bit selects 1us or 5us
// R19: Six-bit base field, reset 0x10
// R20: Software uses 5us only at 1MHz
// R21: Zero latency means no added delay
// R22: Nonzero latency waits value plus six
// R23: Software sets latency nine for zero jitter
`default_nettype none
module msr_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Events from flash controller and cache
    input wire msr_pkg::msr_event_s events,
    // Interrupt gating
    input wire logic irq_raw,
    output logic irq,
    output logic irq_core,
    // Controls toward flash and cache
    output logic flush_instruction_cache,
    output logic bulk_erase_region0,
    output logic bulk_erase_region1,
    output logic [31:0] control_q,
    output logic [31:0] read_control_q,
    output logic [31:0] write_control_q,
    output logic timebase_period_q,
    output logic [5:0] timebase_base_q
);
    logic [3:0] flags_q;
    logic [3:0] ien_q;
    logic cfg_locked_q;
    logic bulk_locked_q;
    logic [7:0] latency_q;
    logic [19:0] hit_count_q;
    logic [19:0] miss_count_q;
    logic counters_running_q;
    msr_pkg::msr_wreq_s wreq_q;
    logic wr_fire;
    logic rd_fire;
    logic wr_ok;
    logic [31:0] rd_d;
    logic rd_ok;
    logic [3:0] set_bits;
    logic [3:0] clr_bits;
    logic [3:0] ev_bits;
    logic hit_max;
    logic miss_max;
    logic begin_cmd;
    logic halt_cmd;
    logic irq_sync1_q;
    logic irq_sync2_q;
    logic [8:0] delay_cnt_q;

    // Write channel capture, either order
    // A low ready flop marks a held beat; no comb path to the bus
    assign wr_fire = !s_awready && !s_wready && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            wreq_q <= '0;
        end else if (clk_en) begin
            if (s_awvalid && s_awready) begin
                s_awready <= 1'b0;
                wreq_q.addr <= {s_awaddr[7:2], 2'b00};
            end else if (wr_fire) begin
                s_awready <= 1'b1;
            end
            if (s_wvalid && s_wready) begin
                s_wready <= 1'b0;
                wreq_q.data <= s_wdata;
                wreq_q.strb <= s_wstrb;
            end else if (wr_fire) begin
                s_wready <= 1'b1;
            end
        end
    end

    function automatic logic wr_to(input logic [7:0] off);
        wr_to = wr_fire && wreq_q.addr == off;
    endfunction

    always_comb begin
        case (wreq_q.addr)
            msr_pkg::OFF_IFS, msr_pkg::OFF_IFC, msr_pkg::OFF_IEN,
            msr_pkg::OFF_LOCK, msr_pkg::OFF_CMD, msr_pkg::OFF_TIMEBASE,
            msr_pkg::OFF_MASSLOCK, msr_pkg::OFF_LATENCY, msr_pkg::OFF_CTRL,
            msr_pkg::OFF_READCTRL, msr_pkg::OFF_WRITECTRL,
            msr_pkg::OFF_BULK_CMD: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp <= msr_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? msr_pkg::RESP_OKAY : msr_pkg::RESP_SLVERR;
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Interrupt flags; set beats clear in the same cycle
    // Decoded in place: hidden reads in a function would not wake an assign
    assign set_bits = (wr_fire && wreq_q.addr == msr_pkg::OFF_IFS)
        ? wreq_q.data[3:0] : 4'h0; // R4
    assign clr_bits = (wr_fire && wreq_q.addr == msr_pkg::OFF_IFC)
        ? wreq_q.data[3:0] : 4'h0; // R5
    assign hit_max = &hit_count_q;
    assign miss_max = &miss_count_q;
    always_comb begin
        ev_bits = 4'h0;
        ev_bits[msr_pkg::BIT_ERASE] = events.erase_done; // R3
        ev_bits[msr_pkg::BIT_WRITE] = events.write_done; // R3
        ev_bits[msr_pkg::BIT_HOF] = counters_running_q && events.hit
            && hit_max; // R2
        ev_bits[msr_pkg::BIT_MOF] = counters_running_q && events.miss
            && miss_max; // R1
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= 4'h0; // R3
        end else if (clk_en) begin
            flags_q <= (flags_q & ~clr_bits) | set_bits | ev_bits;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ien_q <= 4'h0; // R6
        end else if (clk_en && wr_to(msr_pkg::OFF_IEN)) begin
            ien_q <= wreq_q.data[3:0]; // R6
        end
    end

    // Registered so the line is a clean flop output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(flags_q & ien_q); // R7
        end
    end

    // Lock keys
    // Any non-key write locks, so a stray write fails safe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_locked_q <= msr_pkg::CFG_LOCK_RESET[0]; // R9
            bulk_locked_q <= msr_pkg::BULK_LOCK_RESET[0]; // R11
        end else if (clk_en) begin
            if (wr_to(msr_pkg::OFF_LOCK)) begin
                cfg_locked_q <= wreq_q.data[15:0]
                    != msr_pkg::CFG_UNLOCK_CODE; // R8
            end
            if (wr_to(msr_pkg::OFF_MASSLOCK)) begin
                bulk_locked_q <= wreq_q.data[15:0]
                    != msr_pkg::BULK_UNLOCK_CODE; // R10 R11
            end
        end
    end

    // Protected configuration; locked writes are dropped silently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_q <= msr_pkg::CTRL_RESET;
            read_control_q <= msr_pkg::READCTRL_RESET;
            write_control_q <= msr_pkg::WRITECTRL_RESET;
            timebase_period_q <= 1'b0; // R18
            timebase_base_q <= msr_pkg::BASE_RESET; // R19
        end else if (clk_en && !cfg_locked_q) begin // R8
            if (wr_to(msr_pkg::OFF_CTRL)) begin
                control_q <= wreq_q.data & msr_pkg::CTRL_MASK;
            end
            if (wr_to(msr_pkg::OFF_READCTRL)) begin
                read_control_q <= wreq_q.data & msr_pkg::READCTRL_MASK;
            end
            if (wr_to(msr_pkg::OFF_WRITECTRL)) begin
                write_control_q <= wreq_q.data & msr_pkg::WRITECTRL_MASK;
            end
            if (wr_to(msr_pkg::OFF_TIMEBASE)) begin
                timebase_period_q <= wreq_q.data[msr_pkg::BIT_PERIOD]; // R18
                timebase_base_q <= wreq_q.data[5:0]; // R19
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latency_q <= msr_pkg::LATENCY_RESET;
        end else if (clk_en && wr_to(msr_pkg::OFF_LATENCY)) begin
            latency_q <= wreq_q.data[7:0];
        end
    end

    // Command strobes, one cycle each
    // Bulk strobes are gated by the lock at issue time
    assign begin_cmd = wr_fire && wreq_q.addr == msr_pkg::OFF_CMD
        && wreq_q.data[msr_pkg::BIT_BEGIN]; // R12
    assign halt_cmd = wr_fire && wreq_q.addr == msr_pkg::OFF_CMD
        && wreq_q.data[msr_pkg::BIT_HALT]; // R13
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flush_instruction_cache <= 1'b0;
            bulk_erase_region0 <= 1'b0;
            bulk_erase_region1 <= 1'b0;
        end else if (clk_en) begin
            flush_instruction_cache <= wr_to(msr_pkg::OFF_CMD)
                && wreq_q.data[msr_pkg::BIT_FLUSH]; // R14
            bulk_erase_region0 <= wr_to(msr_pkg::OFF_BULK_CMD)
                && wreq_q.data[msr_pkg::BIT_BULK0] && !bulk_locked_q; // R10
            bulk_erase_region1 <= wr_to(msr_pkg::OFF_BULK_CMD)
                && wreq_q.data[msr_pkg::BIT_BULK1] && !bulk_locked_q; // R10
        end
    end

    // Performance counters; at maximum the counter wraps and stops
    // Begin wins over halt when both bits come in one write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_count_q <= '0; // R15
            miss_count_q <= '0; // R16
            counters_running_q <= 1'b0;
        end else if (clk_en) begin
            if (begin_cmd) begin
                hit_count_q <= '0; // R12
                miss_count_q <= '0; // R12
                counters_running_q <= 1'b1; // R12
            end else if (halt_cmd) begin
                counters_running_q <= 1'b0; // R13
            end else if (counters_running_q) begin
                if (events.hit) begin
                    hit_count_q <= hit_count_q + 20'h1; // R15
                end
                if (events.miss) begin
                    miss_count_q <= miss_count_q + 20'h1; // R16
                end
                if ((events.hit && hit_max) || (events.miss && miss_max)) begin
                    counters_running_q <= 1'b0; // R17
                end
            end
        end
    end

    // Interrupt latency gate toward the core
    // Nine-bit count so latency 255 plus six cannot wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_sync1_q <= 1'b0;
            irq_sync2_q <= 1'b0;
        end else if (clk_en) begin
            irq_sync1_q <= irq_raw;
            irq_sync2_q <= irq_sync1_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delay_cnt_q <= '0;
            irq_core <= 1'b0;
        end else if (clk_en) begin
            if (!irq_sync2_q) begin
                delay_cnt_q <= '0;
                irq_core <= 1'b0;
            end else if (latency_q == 8'h00) begin
                irq_core <= 1'b1; // R21
            end else if (delay_cnt_q >= {1'b0, latency_q}
                         + 9'(msr_pkg::LAT_EXTRA) - 9'h1) begin
                irq_core <= 1'b1; // R22
            end else begin
                delay_cnt_q <= delay_cnt_q + 9'h1; // R22
            end
        end
    end

    // Read channel
    // Write-only words read as zero; unmapped ones answer an error
    always_comb begin
        rd_d = 32'h0;
        rd_ok = 1'b1;
        case ({s_araddr[7:2], 2'b00})
            msr_pkg::OFF_IF: rd_d[3:0] = flags_q;
            msr_pkg::OFF_IEN: rd_d[3:0] = ien_q;
            msr_pkg::OFF_LOCK: rd_d[0] = cfg_locked_q; // R9
            msr_pkg::OFF_MASSLOCK: rd_d[0] = bulk_locked_q; // R11
            msr_pkg::OFF_HITS: rd_d[19:0] = hit_count_q;
            msr_pkg::OFF_MISSES: rd_d[19:0] = miss_count_q;
            msr_pkg::OFF_TIMEBASE: begin
                rd_d[msr_pkg::BIT_PERIOD] = timebase_period_q;
                rd_d[5:0] = timebase_base_q;
            end
            msr_pkg::OFF_LATENCY: rd_d[7:0] = latency_q;
            msr_pkg::OFF_CTRL: rd_d = control_q;
            msr_pkg::OFF_READCTRL: rd_d = read_control_q;
            msr_pkg::OFF_WRITECTRL: begin
                rd_d = write_control_q;
                rd_d[8] = counters_running_q; // R17
            end
            msr_pkg::OFF_IFS, msr_pkg::OFF_IFC, msr_pkg::OFF_CMD,
            msr_pkg::OFF_BULK_CMD: rd_d = 32'h0;
            default: rd_ok = 1'b0;
        endcase
    end

    assign rd_fire = s_arvalid && s_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= msr_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (rd_fire) begin
                s_arready <= 1'b0;
                s_rvalid <= 1'b1;
                s_rdata <= rd_d;
                s_rresp <= rd_ok ? msr_pkg::RESP_OKAY : msr_pkg::RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
endmodule // msr_regs
`default_nettype wire

// *** dv/msr_regs_asserts.sv ***
// Purpose: Port-level checks for the memory system register bank
// Assumes: One clock, synchronous active-low reset, clk_en held high
// Notes: Flag and lock state is internal, so checks tie outputs to writes
`default_nettype none
module msr_regs_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    // Events and outputs
    input wire msr_pkg::msr_event_s events,
    input wire logic irq_raw,
    input wire logic irq,
    input wire logic irq_core,
    input wire logic flush_instruction_cache,
    input wire logic bulk_erase_region0,
    input wire logic bulk_erase_region1,
    input wire logic timebase_period_q,
    input wire logic [5:0] timebase_base_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    base_reset_a: assert property ($rose(aresetn) |->
        timebase_base_q == 6'h10 && !timebase_period_q && !irq)
        else $error("timebase or irq not at reset value");
    timebase_write_a: assert property (($changed(timebase_base_q) ||
        $changed(timebase_period_q)) |-> s_bvalid)
        else $error("timebase changed without a write response");
    flush_pulse_a: assert property (flush_instruction_cache |->
        $rose(s_bvalid) ##1 !flush_instruction_cache)
        else $error("flush strobe not a single write pulse");
    bulk_pulse_a: assert property ((bulk_erase_region0 ||
        bulk_erase_region1) |-> $rose(s_bvalid))
        else $error("bulk erase strobe without a write");
    irq_cause_a: assert property ($changed(irq) |->
        $past(s_bvalid) || $past(events, 2) != '0)
        else $error("interrupt moved without a write or event");
    core_delay_a: assert property ($rose(irq_core) |->
        $past(irq_raw, 2))
        else $error("delayed interrupt rose before synchronising");
    rd_answer_a: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    rd_single_a: assert property (s_rvalid && s_rready |=> !s_rvalid)
        else $error("read answer repeated");
    wr_single_a: assert property (s_bvalid && s_bready |=> !s_bvalid)
        else $error("write answer repeated");
endmodule // msr_regs_asserts
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Directed register tests for the memory system bank
// Assumes: Bus waits are bounded, clk_en and write strobes tied on
// Notes: Counter overflow needs 2^20 events, too long for this run
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_awaddr = 8'h00;
    logic [7:0] s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, irq_raw = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic irq, irq_core, fl, b0, b1, per;
    logic [1:0] s_bresp, s_rresp;
    logic [1:0] want = 2'h0;
    logic [31:0] s_rdata;
    logic [5:0] base;
    logic [31:0] ctl, rctl, wctl;
    msr_pkg::msr_event_s events = '0;
    int n_fail = 0;
    int checks_done = 0;
    int n_flush = 0;
    int n_bulk = 0;
    int n;

    always #10 aclk = ~aclk;
    // Counted mid-cycle so a check at the next edge sees the pulse
    always @(negedge aclk) begin
        n_flush += int'(fl);
        n_bulk += int'(b0) + int'(b1);
    end

    msr_regs msr_regs_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .events(events),
        .irq_raw(irq_raw), .irq(irq), .irq_core(irq_core),
        .flush_instruction_cache(fl), .bulk_erase_region0(b0),
        .bulk_erase_region1(b1), .control_q(ctl), .read_control_q(rctl),
        .write_control_q(wctl), .timebase_period_q(per),
        .timebase_base_q(base));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bounded wait: a hung handshake ends the run
    task automatic step(inout int k);
        @(posedge aclk);
        k++;
        if (k > 100) begin
            n_fail++;
            $display("[ERR] %0t wait ran out", $time);
            complete_run();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            step(k);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        s_bready <= 1'b0;
        chk({30'h0, s_bresp}, {30'h0, want});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        int k;
        k = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            step(k);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        s_rready <= 1'b0;
        chk({30'h0, s_rresp}, {30'h0, want});
        if (want == 2'h0) chk(s_rdata, exp);
    endtask

    task automatic ev(input msr_pkg::msr_event_s e, input int cnt);
        repeat (cnt) begin
            @(posedge aclk);
            events <= e;
            @(posedge aclk);
            events <= '0;
        end
    endtask

    // Cycles from raising the line until the delayed line answers
    task automatic lat(output int k);
        k = 0;
        @(posedge aclk);
        irq_raw <= 1'b1;
        do step(k); while (!irq_core);
        irq_raw <= 1'b0;
        repeat (20) @(posedge aclk);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h2c, 32'h0);
        rd(8'h38, 32'h0);
        rd(8'h3c, 32'h0);
        rd(8'h54, 32'h1);
        rd(8'h44, 32'h0);
        rd(8'h48, 32'h0);
        rd(8'h50, 32'h10);
        rd(8'h58, 32'h0);
        chk(ctl, 32'h1);
        chk(rctl, 32'h1);
        chk(wctl, 32'h0);
        want = msr_pkg::RESP_SLVERR;
        rd(8'h60, 32'h0);
        wr(8'h5c, 32'h1);
        want = msr_pkg::RESP_OKAY;
        $display("reset test done");
        wr(8'h30, 32'hf);
        rd(8'h2c, 32'hf);
        chk({31'h0, irq}, 32'h0);
        wr(8'h38, 32'h2);
        rd(8'h38, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(8'h34, 32'h2);
        rd(8'h2c, 32'hd);
        chk({31'h0, irq}, 32'h0);
        wr(8'h34, 32'hd);
        ev(4'h2, 1);
        rd(8'h2c, 32'h2);
        ev(4'h1, 1);
        rd(8'h2c, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wr(8'h34, 32'hf);
        $display("flag test done");
        wr(8'h3c, 32'h1234);
        rd(8'h3c, 32'h1);
        wr(8'h04, 32'h9f);
        chk(rctl, 32'h1);
        wr(8'h50, 32'h10005);
        rd(8'h50, 32'h10);
        wr(8'h3c, 32'h1b71);
        rd(8'h3c, 32'h0);
        wr(8'h00, 32'h0);
        chk(ctl, 32'h0);
        wr(8'h04, 32'h9f);
        chk(rctl, 32'h9f);
        wr(8'h50, 32'h10005);
        rd(8'h50, 32'h10005);
        chk({25'h0, per, base}, 32'h45);
        $display("config lock test done");
        wr(8'h0c, 32'h300);
        chk(n_bulk, 32'h0);
        wr(8'h54, 32'h631a);
        rd(8'h54, 32'h0);
        wr(8'h0c, 32'h300);
        chk(n_bulk, 32'h2);
        wr(8'h54, 32'h0);
        rd(8'h54, 32'h1);
        wr(8'h0c, 32'h100);
        chk(n_bulk, 32'h2);
        $display("bulk lock test done");
        wr(8'h40, 32'h2);
        ev(4'h8, 3);
        ev(4'h4, 2);
        rd(8'h44, 32'h3);
        rd(8'h48, 32'h2);
        rd(8'h08, 32'h100);
        wr(8'h40, 32'h4);
        ev(4'h8, 2);
        rd(8'h44, 32'h3);
        wr(8'h40, 32'h2);
        rd(8'h44, 32'h0);
        rd(8'h48, 32'h0);
        wr(8'h40, 32'h1);
        chk(n_flush, 32'h1);
        $display("counter test done");
        lat(n);
        chk({31'h0, n <= 4}, 32'h1);
        wr(8'h58, 32'h3);
        rd(8'h58, 32'h3);
        lat(n);
        chk({31'h0, n >= 9}, 32'h1);
        wr(8'h58, 32'h9);
        rd(8'h58, 32'h9);
        lat(n);
        chk({31'h0, n >= 15}, 32'h1);
        $display("latency test done");
        complete_run();
    end
endmodule // tb_top

bind msr_regs msr_regs_asserts msr_regs_asserts_inst (.aclk(aclk),
    .aresetn(aresetn), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .events(events), .irq_raw(irq_raw), .irq(irq),
    .irq_core(irq_core), .flush_instruction_cache(flush_instruction_cache),
    .bulk_erase_region0(bulk_erase_region0),
    .bulk_erase_region1(bulk_erase_region1),
    .timebase_period_q(timebase_period_q),
    .timebase_base_q(timebase_base_q));
`default_nettype wire
